// File: verilog/synth_ctrl_pkg.sv
// Constants for the clock synthesizer override, trim and reset control.
// Assumes an 8-bit register port with byte addresses as printed.
package synth_ctrl_pkg;
   localparam int          ADDR_WIDTH        = 8;
   localparam int          DATA_WIDTH        = 8;
   localparam int          TRIM_WIDTH        = 7;
   localparam int          MODE_WIDTH        = 2;
   // Register offsets
   localparam logic [7:0]  PIN_OVERRIDE_ADDR = 8'h58;
   localparam logic [7:0]  TRIM_ADDR         = 8'h59;
   localparam logic [7:0]  RESET_ADDR        = 8'h5c;
   localparam logic [7:0]  CAL_CONTROL_ADDR  = 8'h5d;
   localparam logic [7:0]  CAL_STATUS_ADDR   = 8'h5e;
   // Reset values
   localparam logic [7:0]  PIN_OVERRIDE_RST  = 8'h00;
   localparam logic [6:0]  TRIM_RST          = 7'h00;
   localparam logic [7:0]  CAL_CONTROL_RST   = 8'h40;
   // Field positions in the pin override, reset and calibration registers
   localparam int          OVR_EN_BIT        = 7;
   localparam int          SECOND_MODE_LSB   = 4;
   localparam int          FIRST_MODE_LSB    = 2;
   localparam int          SE_SELECT_BIT     = 1;
   localparam int          SYNTH_EN_BIT      = 0;
   localparam int          RESET_BIT         = 0;
   localparam int          CAL_EN_BIT        = 0;
   localparam int          CAL_DONE_BIT      = 0;
   localparam int          SETTLE_LSB        = 4;
   localparam int          SETTLE_WIDTH      = 3;
   // Output modes of a divided-reference output
   typedef enum logic [1:0] {
      REFOUT_OFF  = 2'b00,
      REFOUT_DIV1 = 2'b01,
      REFOUT_DIV2 = 2'b10,
      REFOUT_DIV4 = 2'b11
   } refout_mode_type;
endpackage

// File: verilog/refout_divider.sv
// Divided-reference output generator.
// Assumes the reference clock is sampled as a level on clk.
`timescale 1ns/1ps
module refout_divider
   import synth_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            resetn,
   // Reference and selection
   input  wire logic            ref_in,
   input  wire refout_mode_type mode,
   // Output
   output logic                 refout,
   output logic                 active
);
   logic       ref_d_reg;
   logic [1:0] count_reg;
   logic       rise;

   assign rise = ref_in & ~ref_d_reg;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ref_d_reg <= 1'b0;
      end else begin
         ref_d_reg <= ref_in;
      end
   end

   // Counts reference rising edges; bit 0 toggles at half, bit 1 at quarter
   always_ff @(posedge clk) begin
      if (!resetn || mode == REFOUT_OFF) begin
         count_reg <= 2'h0;
      end else if (rise) begin
         count_reg <= count_reg + 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         refout <= 1'b0;
         active <= 1'b0;
      end else begin
         active <= (mode != REFOUT_OFF);
         case (mode)
            REFOUT_OFF:  refout <= 1'b0;
            REFOUT_DIV1: refout <= ref_in;
            REFOUT_DIV2: refout <= count_reg[0];
            REFOUT_DIV4: refout <= count_reg[1];
            default:     refout <= 1'b0;
         endcase
      end
   end
endmodule

// File: verilog/pll_override_trim_reset_ctrl.sv
// Synthesizer pin override, oscillator trim and synthesizer reset control.
// Assumes a simple synchronous register port and a calibration engine
// outside that tunes the trim through the load port below.
// Function
// - Override bit 7 picks registers over strap pins for synthesizer setup.
// - Override on: bits 5:4 set second output off, div1, div2, div4.
// - Override off: second output function comes from the clock straps.
// - Second output never clocks unless first output clocks too.
// - Override on: bits 3:2 set first output off, div1, div2, div4.
// - Override off: first output function comes from the clock straps.
// - Override on: bit 1 selects single-ended reference input.
// - Override on: bit 0 enables the synthesizer.
// - Seven-bit trim sets oscillator frequency, loaded by calibration.
// - Trim is readable after calibration and may be written back.
// - Reset bit 0 holds synthesizer and calibration logic in reset.
// - With calibration enabled, calibration starts when reset clears.
// - Calibration done reads one after completion or when skipped.
`timescale 1ns/1ps
module pll_override_trim_reset_ctrl
   import synth_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    resetn,
   // Register port
   input  wire logic [ADDR_WIDTH-1:0]   reg_addr,
   input  wire logic                    reg_write,
   input  wire logic                    reg_read,
   input  wire logic [DATA_WIDTH-1:0]   reg_wdata,
   output logic      [DATA_WIDTH-1:0]   reg_rdata,
   // Strap pins
   input  wire logic                    synth_enable_pin,
   input  wire logic                    single_ended_select_pin,
   input  wire logic                    clock_strap_zero,
   input  wire logic                    clock_strap_one,
   // Reference clock to divide
   input  wire logic                    reference_clock,
   // Calibration engine
   input  wire logic                    cal_trim_load,
   input  wire logic [TRIM_WIDTH-1:0]   cal_trim_value,
   input  wire logic                    cal_complete,
   output logic                         calibration_running,
   output logic [SETTLE_WIDTH-1:0]      cal_settle,
   // Synthesizer controls
   output logic                         synth_enable,
   output logic                         single_ended_ref_input,
   output logic [TRIM_WIDTH-1:0]        oscillator_trim,
   output logic                         synth_in_reset,
   // Divided reference outputs
   output logic                         first_reference_output,
   output logic                         second_reference_output
);
   logic [DATA_WIDTH-1:0] override_reg;
   logic [TRIM_WIDTH-1:0] trim_reg;
   logic                  reset_bit_reg;
   logic [DATA_WIDTH-1:0] cal_control_reg;
   logic                  done_reg;
   logic                  running_reg;
   logic                  override_enable;
   logic                  calibration_enable;
   refout_mode_type       first_mode;
   refout_mode_type       second_mode;
   refout_mode_type       strap_first;
   refout_mode_type       strap_second;
   logic                  first_active;
   logic                  first_refout;
   logic                  second_refout;

   assign override_enable    = override_reg[OVR_EN_BIT];
   assign calibration_enable = cal_control_reg[CAL_EN_BIT];

   // Field slices below assume a byte-wide port with room above the trim
   if (TRIM_WIDTH >= DATA_WIDTH || MODE_WIDTH != 2 ||
       SETTLE_LSB + SETTLE_WIDTH > DATA_WIDTH) begin : g_width_check
      $error("unsupported register field widths");
   end

   // Fields are stored regardless of override so they apply on enable
   always_ff @(posedge clk) begin
      if (!resetn) begin
         override_reg <= PIN_OVERRIDE_RST;
      end else if (reg_write && reg_addr == PIN_OVERRIDE_ADDR) begin
         override_reg <= reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         reset_bit_reg   <= 1'b0;
         cal_control_reg <= CAL_CONTROL_RST;
      end else if (reg_write) begin
         if (reg_addr == RESET_ADDR) begin
            reset_bit_reg <= reg_wdata[RESET_BIT];
         end else if (reg_addr == CAL_CONTROL_ADDR) begin
            cal_control_reg <= reg_wdata;
         end
      end
   end

   // Engine load while calibration runs wins over a software write in the same cycle
   always_ff @(posedge clk) begin
      if (!resetn) begin
         trim_reg <= TRIM_RST;
      end else if (cal_trim_load && running_reg) begin
         trim_reg <= cal_trim_value;
      end else if (reg_write && reg_addr == TRIM_ADDR) begin
         trim_reg <= reg_wdata[TRIM_WIDTH-1:0];
      end
   end

   // Calibration runs from reset release until the engine reports done
   // Setting the reset bit mid-run drops both flags, so done is lost too
   always_ff @(posedge clk) begin
      if (!resetn || reset_bit_reg) begin
         running_reg <= 1'b0;
         done_reg    <= 1'b0;
      end else if (!calibration_enable && !running_reg) begin
         done_reg <= 1'b1;
      end else if (!done_reg && !running_reg) begin
         running_reg <= 1'b1;
      end else if (running_reg && cal_complete) begin
         running_reg <= 1'b0;
         done_reg    <= 1'b1;
      end
   end

   // Strap coding: straps 00 off, 01 first div1, 10 both div2, 11 both div4
   always_comb begin
      strap_first  = refout_mode_type'({clock_strap_one, clock_strap_zero});
      strap_second = REFOUT_OFF;
      if (clock_strap_one) begin
         strap_second = strap_first;
      end
   end

   always_comb begin
      if (override_enable) begin
         first_mode  = refout_mode_type'(
            override_reg[FIRST_MODE_LSB +: MODE_WIDTH]);
         second_mode = refout_mode_type'(
            override_reg[SECOND_MODE_LSB +: MODE_WIDTH]);
      end else begin
         first_mode  = strap_first;
         second_mode = strap_second;
      end
   end

   refout_divider first_divider (
      .clk    (clk),
      .resetn (resetn),
      .ref_in (reference_clock),
      .mode   (first_mode),
      .refout (first_refout),
      .active (first_active)
   );

   refout_divider second_divider (
      .clk    (clk),
      .resetn (resetn),
      .ref_in (reference_clock),
      .mode   (second_mode),
      .refout (second_refout),
      .active ()
   );

   always_ff @(posedge clk) begin
      if (!resetn) begin
         synth_enable            <= 1'b0;
         single_ended_ref_input  <= 1'b0;
         first_reference_output  <= 1'b0;
         second_reference_output <= 1'b0;
      end else begin
         synth_enable <= override_enable ?
            override_reg[SYNTH_EN_BIT] : synth_enable_pin;
         single_ended_ref_input <= override_enable ?
            override_reg[SE_SELECT_BIT] : single_ended_select_pin;
         // Gate follows the first divider's registered active flag, so a
         // switch-off of the first output also silences the second
         first_reference_output  <= first_refout;
         second_reference_output <= second_refout & first_active;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         oscillator_trim     <= TRIM_RST;
         synth_in_reset      <= 1'b0;
         calibration_running <= 1'b0;
         cal_settle          <= CAL_CONTROL_RST[SETTLE_LSB +: SETTLE_WIDTH];
      end else begin
         oscillator_trim     <= trim_reg;
         synth_in_reset      <= reset_bit_reg;
         calibration_running <= running_reg;
         cal_settle <= cal_control_reg[SETTLE_LSB +: SETTLE_WIDTH];
      end
   end

   // Read data registered one cycle after the read strobe
   always_ff @(posedge clk) begin
      if (!resetn) begin
         reg_rdata <= '0;
      end else if (reg_read) begin
         if (reg_addr == PIN_OVERRIDE_ADDR) begin
            reg_rdata <= override_reg;
         end else if (reg_addr == TRIM_ADDR) begin
            reg_rdata <= {1'b0, trim_reg};
         end else if (reg_addr == RESET_ADDR) begin
            reg_rdata <= {7'h00, reset_bit_reg};
         end else if (reg_addr == CAL_CONTROL_ADDR) begin
            reg_rdata <= cal_control_reg;
         end else if (reg_addr == CAL_STATUS_ADDR) begin
            reg_rdata <= {7'h00, done_reg};
         end else begin
            reg_rdata <= '0;
         end
      end
   end
endmodule

// File: testbench/pll_ctrl_monitor.sv
// Checker for the synthesizer pin override, trim and reset control.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module pll_ctrl_monitor
   import synth_ctrl_pkg::*;
(
   // Clock, reset and register port
   input wire logic                  clk,
   input wire logic                  resetn,
   input wire logic [ADDR_WIDTH-1:0] reg_addr,
   input wire logic                  reg_write,
   input wire logic [DATA_WIDTH-1:0] reg_wdata,
   input wire logic                  reg_read,
   input wire logic [DATA_WIDTH-1:0] reg_rdata,
   // Straps and calibration engine
   input wire logic                  synth_enable_pin,
   input wire logic                  single_ended_select_pin,
   input wire logic                  clock_strap_zero,
   input wire logic                  clock_strap_one,
   input wire logic                  cal_trim_load,
   input wire logic [TRIM_WIDTH-1:0] cal_trim_value,
   input wire logic                  cal_complete,
   input wire logic                  calibration_running,
   // Synthesizer controls and outputs
   input wire logic                  synth_enable,
   input wire logic                  single_ended_ref_input,
   input wire logic [TRIM_WIDTH-1:0] oscillator_trim,
   input wire logic                  synth_in_reset,
   input wire logic                  first_reference_output,
   input wire logic                  second_reference_output
);
   logic [7:0] ovr_reg;
   logic       en_src;
   logic       se_src;
   logic       first_off;
   logic       second_off;
   assign en_src = ovr_reg[7] ? ovr_reg[0] : synth_enable_pin;
   assign se_src = ovr_reg[7] ? ovr_reg[1] : single_ended_select_pin;
   assign first_off = ovr_reg[7] ? ovr_reg[3:2] == 2'h0
                                 : !(clock_strap_one || clock_strap_zero);
   assign second_off = ovr_reg[7] ? ovr_reg[5:4] == 2'h0 : !clock_strap_one;
   // Shadow of the override register, kept from the write strobes alone
   always_ff @(posedge clk) begin
      if (!resetn)
         ovr_reg <= 8'h00;
      else if (reg_write && reg_addr == PIN_OVERRIDE_ADDR)
         ovr_reg <= reg_wdata;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Four quiet cycles cover the two-stage output latency
   sequence first_quiet;
      first_off [*4];
   endsequence
   sequence second_quiet;
      (first_off || second_off) [*4];
   endsequence
   a_synth_en_src: assert property (
      $past(resetn) |-> synth_enable == $past(en_src))
      else $error("synth enable source wrong");
   a_se_ref_src: assert property (
      $past(resetn) |-> single_ended_ref_input == $past(se_src))
      else $error("single ended select source wrong");
   a_first_out_off: assert property (
      first_quiet |-> !first_reference_output)
      else $error("first output clocks while off");
   a_second_gated: assert property (
      second_quiet |-> !second_reference_output)
      else $error("second output clocks while off or ungated");
   a_trim_load: assert property (
      calibration_running && cal_trim_load
      |-> ##2 oscillator_trim == $past(cal_trim_value, 2))
      else $error("engine trim load lost");
   a_reset_holds: assert property (
      synth_in_reset && $past(synth_in_reset) |-> !calibration_running)
      else $error("calibration runs in reset");
   a_reset_rdback: assert property (
      reg_read && !reg_write && reg_addr == RESET_ADDR
      |=> reg_rdata == {7'h00, synth_in_reset})
      else $error("reset bit read disagrees with output");
   a_cal_finish: assert property (
      calibration_running && cal_complete && !synth_in_reset
      |-> ##2 !calibration_running)
      else $error("calibration did not stop");
endmodule

// File: testbench/pll_override_trim_reset_ctrl_tb_top.sv
// Self-checking bench for the synthesizer override, trim and reset block.
// Assumes the design package and both modules are compiled first.
`timescale 1ns/1ps
module pll_override_trim_reset_ctrl_tb_top;
   import synth_ctrl_pkg::*;
   logic        clk, resetn, reg_write, reg_read, reference_clock;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, mdl [0:255];
   logic        synth_enable_pin, single_ended_select_pin;
   logic        clock_strap_zero, clock_strap_one, cal_trim_load;
   logic        cal_complete, calibration_running, synth_enable;
   logic [6:0]  cal_trim_value, oscillator_trim;
   logic [2:0]  cal_settle, refc;
   logic        single_ended_ref_input, synth_in_reset;
   logic        first_reference_output, second_reference_output;
   logic [31:0] lfsr;
   int          n_errors, n_tests, c1, c2;
   pll_override_trim_reset_ctrl u_pll_override_trim_reset_ctrl (.*);
   // Reference is one eighth of clk, slow enough for the divide modes
   assign reference_clock = refc[2];
   always @(posedge clk) refc <= refc + 3'h1;
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic near(input int c, input int md);
      int e;
      e = md == 0 ? 0 : 16 >> (md - 1);
      return c >= e - 1 && c <= e + 1;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge clk);
      reg_write <= 1'h0;
      case (a)
         PIN_OVERRIDE_ADDR, CAL_CONTROL_ADDR: mdl[a] = d;
         TRIM_ADDR: mdl[a] = d & 8'h7f;
         RESET_ADDR: mdl[a] = d & 8'h01;
         default: ;
      endcase
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'h1;
      @(posedge clk);
      reg_read <= 1'h0;
      @(negedge clk);
      chk(reg_rdata, mdl[a]);
   endtask
   // Counts rising edges of both outputs over 128 cycles after settling
   task automatic count(output int a, output int b);
      logic pa, pb;
      a = 0;
      b = 0;
      repeat (8) @(negedge clk);
      repeat (128) begin
         pa = first_reference_output;
         pb = second_reference_output;
         @(negedge clk);
         a += int'(!pa && first_reference_output);
         b += int'(!pb && second_reference_output);
      end
   endtask
   task automatic wrap_up;
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      wrap_up();
   end
   initial begin
      {resetn, reg_write, reg_read, cal_trim_load, cal_complete} = 5'h00;
      {synth_enable_pin, single_ended_select_pin} = 2'h0;
      {clock_strap_zero, clock_strap_one} = 2'h0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      cal_trim_value = 7'h00;
      refc = 3'h0;
      lfsr = 32'he1fa;
      foreach (mdl[i]) mdl[i] = 8'h00;
      mdl[CAL_CONTROL_ADDR] = 8'h40;
      mdl[CAL_STATUS_ADDR] = 8'h01;
      repeat (8) @(posedge clk);
      resetn <= 1'h1;
      for (logic [7:0] a = 8'h58; a < 8'h5f; a++) rd(a);
      chk(cal_settle, {5'h00, mdl[CAL_CONTROL_ADDR][6:4]});
      repeat (12) begin
         lfsr = lfsr_next(lfsr);
         @(posedge clk);
         synth_enable_pin <= lfsr[8];
         single_ended_select_pin <= lfsr[9];
         wr(PIN_OVERRIDE_ADDR, lfsr[7:0] & 8'hbf);
         repeat (3) @(negedge clk);
         chk(synth_enable, lfsr[7] ? lfsr[0] : lfsr[8]);
         chk(single_ended_ref_input, lfsr[7] ? lfsr[1] : lfsr[9]);
         rd(PIN_OVERRIDE_ADDR);
      end
      for (int m = 0; m < 16; m++) begin
         wr(PIN_OVERRIDE_ADDR, 8'h80 | 8'(m << 2));
         count(c1, c2);
         chk(near(c1, m[1:0]), 8'h01);
         chk(near(c2, m[1:0] == 0 ? 0 : m[3:2]), 8'h01);
      end
      // Override fields set but disabled, so the straps must rule
      wr(PIN_OVERRIDE_ADDR, 8'h3c);
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         clock_strap_zero <= s[0];
         clock_strap_one <= s[1];
         count(c1, c2);
         chk(near(c1, s), 8'h01);
         chk(near(c2, s < 2 ? 0 : s), 8'h01);
      end
      wr(RESET_ADDR, 8'h01);
      mdl[CAL_STATUS_ADDR] = 8'h00;
      rd(CAL_STATUS_ADDR);
      chk(synth_in_reset, 8'h01);
      rd(RESET_ADDR);
      wr(CAL_CONTROL_ADDR, 8'h31);
      wr(RESET_ADDR, 8'h00);
      // Engine state and its output register each add one edge
      repeat (3) @(negedge clk);
      chk(calibration_running, 8'h01);
      chk(cal_settle, {5'h00, mdl[CAL_CONTROL_ADDR][6:4]});
      // Engine loads a trim while it runs, then reports completion
      @(posedge clk);
      cal_trim_load <= 1'h1;
      cal_trim_value <= lfsr[6:0];
      @(posedge clk);
      cal_trim_load <= 1'h0;
      cal_complete <= 1'h1;
      @(posedge clk);
      cal_complete <= 1'h0;
      repeat (2) @(negedge clk);
      chk(calibration_running, 8'h00);
      mdl[TRIM_ADDR] = {1'h0, lfsr[6:0]};
      mdl[CAL_STATUS_ADDR] = 8'h01;
      rd(CAL_STATUS_ADDR);
      rd(TRIM_ADDR);
      chk(oscillator_trim, lfsr[6:0]);
      wr(TRIM_ADDR, 8'h2a);
      rd(TRIM_ADDR);
      wrap_up();
   end
endmodule
bind pll_override_trim_reset_ctrl pll_ctrl_monitor u_pll_ctrl_monitor (.*);
